// ### logic/deas_pkg.sv
package deas_pkg;

  // Addresses on the device's special-register port.
  localparam logic [7:0] DEV_ADDR_REG  = 8'h2a;
  localparam logic [7:0] DEV_DATA_REG  = 8'h2b;
  localparam logic [7:0] DEV_PTR_LO    = 8'h03;
  localparam logic [7:0] DEV_PTR_HI    = 8'h04;
  localparam logic [7:0] DEV_IAP       = 8'h02;

  // Pointer values that open the control register in sector 1.
  localparam logic [7:0] CTRL_PTR_LO   = 8'h40;
  localparam logic [7:0] CTRL_PTR_HI   = 8'h01;
  localparam logic [7:0] SECTOR0_HI    = 8'h00;

  // Control register bits and the values written to it.
  localparam int unsigned RD_LAUNCH_BIT = 0;
  localparam int unsigned RD_PERMIT_BIT = 1;
  localparam int unsigned WR_LAUNCH_BIT = 2;
  localparam int unsigned WR_PERMIT_BIT = 3;
  localparam logic [7:0] CTRL_RD_PERMIT = 8'h02;
  localparam logic [7:0] CTRL_RD_GO     = 8'h03;
  localparam logic [7:0] CTRL_WR_PERMIT = 8'h08;
  localparam logic [7:0] CTRL_WR_GO     = 8'h0c;
  localparam logic [7:0] CTRL_CLEAR     = 8'h00;
  localparam int unsigned NV_ADDR_W     = 6;

  // APB register offsets.
  localparam logic [11:0] CMD_OFF      = 12'h000;
  localparam logic [11:0] CFG_OFF      = 12'h004;
  localparam logic [11:0] STAT_OFF     = 12'h008;
  localparam logic [11:0] IRQ_STAT_OFF = 12'h00c;
  localparam logic [11:0] IRQ_MASK_OFF = 12'h010;

  // Field positions.
  localparam int unsigned CMD_RD_BIT     = 0;
  localparam int unsigned CMD_WR_BIT     = 1;
  localparam int unsigned CFG_ADDR_LSB   = 0;
  localparam int unsigned CFG_DATA_LSB   = 8;
  localparam int unsigned CFG_VFY_BIT    = 16;
  localparam int unsigned CFG_KEEP_BIT   = 17;
  localparam int unsigned CFG_GIE_BIT    = 18;
  localparam int unsigned CFG_SLEEP_BIT  = 19;
  localparam int unsigned STAT_BUSY_BIT  = 0;
  localparam int unsigned STAT_VFY_BIT   = 1;
  localparam int unsigned STAT_BYTE_LSB  = 8;

  // Interrupt status bits.
  localparam int unsigned IRQ_W          = 4;
  localparam int unsigned IRQ_RD_DONE    = 0;
  localparam int unsigned IRQ_WR_DONE    = 1;
  localparam int unsigned IRQ_VFY_FAIL   = 2;
  localparam int unsigned IRQ_REFUSED    = 3;
  localparam logic [3:0]  IRQ_MASK_RST   = 4'h0;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_ISSUE,
    ST_WAIT
  } deas_state_t;

  typedef struct packed {
    logic       we;
    logic       poll;
    logic [2:0] poll_bit;
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       cleanup;
    logic       irq_off;
    logic       irq_on;
    logic       capture;
    logic       last;
  } deas_op_t;

endpackage : deas_pkg

// ### logic/deas_sfr_port.sv
module deas_sfr_port (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       go,
  input  wire logic       go_we,
  input  wire logic [7:0] go_addr,
  input  wire logic [7:0] go_wdata,
  output logic            done,
  output logic [7:0]      rdata,
  output logic [7:0]      dev_addr,
  output logic [7:0]      dev_wdata,
  output logic            dev_wr,
  output logic            dev_rd,
  input  wire logic [7:0] dev_rdata
);

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
    logic       done;
    logic [7:0] rdata;
  } deas_port_t;

  deas_port_t st_ff;
  deas_port_t nxt_st;

  // One access takes one strobe cycle; the device answers reads within it.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.wr   = go & go_we;
    nxt_st.rd   = go & ~go_we;
    nxt_st.done = st_ff.wr | st_ff.rd;
    if (go) begin
      nxt_st.addr  = go_addr;
      nxt_st.wdata = go_wdata;
    end
    if (st_ff.rd) begin
      nxt_st.rdata = dev_rdata;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign dev_addr  = st_ff.addr;
  assign dev_wdata = st_ff.wdata;
  assign dev_wr    = st_ff.wr;
  assign dev_rd    = st_ff.rd;
  assign done      = st_ff.done;
  assign rdata     = st_ff.rdata;

  a_one_strobe: assert property (@(posedge clk) disable iff (!arst_n) !(dev_wr && dev_rd))
    else $error("read and write strobes together");

  a_done_next: assert property (@(posedge clk) disable iff (!arst_n)
    (dev_rd || dev_wr) |=> done && !(dev_rd || dev_wr))
    else $error("access not completed in one cycle");

endmodule : deas_sfr_port

// ### logic/deas_irq.sv
module deas_irq (
  input  wire logic                        clk,
  input  wire logic                        arst_n,
  input  wire logic [deas_pkg::IRQ_W-1:0]  set,
  input  wire logic                        clr_we,
  input  wire logic [deas_pkg::IRQ_W-1:0]  clr_data,
  input  wire logic                        mask_we,
  input  wire logic [deas_pkg::IRQ_W-1:0]  mask_data,
  output logic [deas_pkg::IRQ_W-1:0]       status,
  output logic [deas_pkg::IRQ_W-1:0]       mask,
  output logic                             irq
);

  typedef struct packed {
    logic [deas_pkg::IRQ_W-1:0] stat;
    logic [deas_pkg::IRQ_W-1:0] mask;
    logic                       irq;
  } deas_irq_t;

  deas_irq_t st_ff;
  deas_irq_t nxt_st;

  // A new event beats a write-one-to-clear in the same cycle.
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.stat = (st_ff.stat & ~(clr_we ? clr_data : '0)) | set;
    if (mask_we) begin
      nxt_st.mask = mask_data;
    end
    nxt_st.irq = |(nxt_st.stat & nxt_st.mask);
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= {{deas_pkg::IRQ_W{1'b0}}, deas_pkg::IRQ_MASK_RST, 1'b0};
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign status = st_ff.stat;
  assign mask   = st_ff.mask;
  assign irq    = st_ff.irq;

  a_irq_level: assert property (@(posedge clk) disable iff (!arst_n) irq == |(status & mask))
    else $error("interrupt output does not follow status and mask");

  a_set_wins: assert property (@(posedge clk) disable iff (!arst_n)
    set[deas_pkg::IRQ_WR_DONE] |=> status[deas_pkg::IRQ_WR_DONE])
    else $error("write-done event lost");

endmodule : deas_irq

// ### logic/deas_host.sv
// Overview of operation
// - Write launch is the very next device access after setting write permit.
// - Global interrupt enable is low before launch and restored once the write started.
// - Sleep is never requested while a read or write is in progress.
// - Every read reloads the address register and sets the read launch again.
// - Write permit is cleared again as soon as the write completes.
// - Control register is reached via pointer low 40H, high 01H, indirect port.
// - Read: address, read permit, read launch, poll launch clear, then read data.
// - Write: address, data, write permit, write launch, poll launch clear.
// - With no more reads planned, clear control register, then pointer high byte.
// - Optionally read each written byte back and compare it.
module deas_host (
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  output logic [7:0]       dev_addr,
  output logic [7:0]       dev_wdata,
  output logic             dev_wr,
  output logic             dev_rd,
  input  wire logic [7:0]  dev_rdata,
  output logic             global_irq_enable,
  output logic             sleep_req
);

  typedef struct packed {
    deas_pkg::deas_state_t state;
    logic                  is_wr;
    logic                  verifying;
    logic [3:0]            step;
    logic [5:0]            cfg_addr;
    logic [7:0]            cfg_data;
    logic                  cfg_vfy;
    logic                  cfg_keep;
    logic                  cfg_gie;
    logic                  cfg_sleep;
    logic [7:0]            rd_byte;
    logic                  vfy_ok;
    logic                  irq_hold;
    logic                  gie_out;
    logic                  sleep_out;
    logic [31:0]           prdata;
    logic [7:0]            sh_plo;
    logic [7:0]            sh_phi;
    logic [7:0]            sh_iap;
    logic                  addr_fresh;
    logic [7:0]            last_poll;
  } deas_host_t;

  deas_host_t st_ff;
  deas_host_t nxt_st;

  deas_pkg::deas_op_t           op;
  logic                         port_go;
  logic                         port_done;
  logic [7:0]                   port_rdata;
  logic [deas_pkg::IRQ_W-1:0]   irq_set;
  logic [deas_pkg::IRQ_W-1:0]   irq_status;
  logic [deas_pkg::IRQ_W-1:0]   irq_mask;
  logic                         apb_wr;
  logic                         busy;
  logic                         finish;

  function automatic logic addr_mapped(input logic [11:0] a);
    addr_mapped = (a == deas_pkg::CMD_OFF) || (a == deas_pkg::CFG_OFF) ||
                  (a == deas_pkg::STAT_OFF) || (a == deas_pkg::IRQ_STAT_OFF) ||
                  (a == deas_pkg::IRQ_MASK_OFF);
  endfunction : addr_mapped

  // One device access per step; the pointer is always reloaded so that a
  // sequence never trusts what an earlier one left behind.
  function automatic deas_pkg::deas_op_t seq_op(input logic       wr,
                                                input logic [3:0] step,
                                                input logic [5:0] a,
                                                input logic [7:0] d);
    deas_pkg::deas_op_t o;
    o    = '0;
    o.we = 1'b1;
    if (wr) begin
      case (step)
        4'h0: begin o.addr = deas_pkg::DEV_ADDR_REG; o.wdata = {2'b00, a}; end
        4'h1: begin o.addr = deas_pkg::DEV_DATA_REG; o.wdata = d; end
        4'h2: begin o.addr = deas_pkg::DEV_PTR_LO; o.wdata = deas_pkg::CTRL_PTR_LO; end
        4'h3: begin
          o.addr = deas_pkg::DEV_PTR_HI; o.wdata = deas_pkg::CTRL_PTR_HI; o.irq_off = 1'b1;
        end
        4'h4: begin o.addr = deas_pkg::DEV_IAP; o.wdata = deas_pkg::CTRL_WR_PERMIT; end
        4'h5: begin
          o.addr = deas_pkg::DEV_IAP; o.wdata = deas_pkg::CTRL_WR_GO; o.irq_on = 1'b1;
        end
        4'h6: begin
          o.we = 1'b0; o.poll = 1'b1; o.addr = deas_pkg::DEV_IAP;
          o.poll_bit = 3'(deas_pkg::WR_LAUNCH_BIT);
        end
        4'h7: begin o.addr = deas_pkg::DEV_IAP; o.wdata = deas_pkg::CTRL_CLEAR; end
        default: begin
          o.addr = deas_pkg::DEV_PTR_HI; o.wdata = deas_pkg::SECTOR0_HI; o.last = 1'b1;
        end
      endcase
    end else begin
      case (step)
        4'h0: begin o.addr = deas_pkg::DEV_ADDR_REG; o.wdata = {2'b00, a}; end
        4'h1: begin o.addr = deas_pkg::DEV_PTR_LO; o.wdata = deas_pkg::CTRL_PTR_LO; end
        4'h2: begin o.addr = deas_pkg::DEV_PTR_HI; o.wdata = deas_pkg::CTRL_PTR_HI; end
        4'h3: begin o.addr = deas_pkg::DEV_IAP; o.wdata = deas_pkg::CTRL_RD_PERMIT; end
        4'h4: begin o.addr = deas_pkg::DEV_IAP; o.wdata = deas_pkg::CTRL_RD_GO; end
        4'h5: begin
          o.we = 1'b0; o.poll = 1'b1; o.addr = deas_pkg::DEV_IAP;
          o.poll_bit = 3'(deas_pkg::RD_LAUNCH_BIT);
        end
        4'h6: begin
          o.addr = deas_pkg::DEV_IAP; o.wdata = deas_pkg::CTRL_CLEAR; o.cleanup = 1'b1;
        end
        4'h7: begin
          o.addr = deas_pkg::DEV_PTR_HI; o.wdata = deas_pkg::SECTOR0_HI; o.cleanup = 1'b1;
        end
        default: begin
          o.we = 1'b0; o.addr = deas_pkg::DEV_DATA_REG; o.capture = 1'b1; o.last = 1'b1;
        end
      endcase
    end
    seq_op = o;
  endfunction : seq_op

  always_comb begin
    nxt_st  = st_ff;
    op      = seq_op(st_ff.is_wr, st_ff.step, st_ff.cfg_addr, st_ff.cfg_data);
    port_go = 1'b0;
    irq_set = '0;
    finish  = 1'b0;
    apb_wr  = psel & penable & pwrite;
    busy    = st_ff.state != deas_pkg::ST_IDLE;

    // Arguments stay frozen while a sequence runs.
    if (apb_wr && paddr == deas_pkg::CFG_OFF) begin
      if (busy) begin
        irq_set[deas_pkg::IRQ_REFUSED] = 1'b1;
      end else begin
        nxt_st.cfg_addr  = pwdata[deas_pkg::CFG_ADDR_LSB +: 6];
        nxt_st.cfg_data  = pwdata[deas_pkg::CFG_DATA_LSB +: 8];
        nxt_st.cfg_vfy   = pwdata[deas_pkg::CFG_VFY_BIT];
        nxt_st.cfg_keep  = pwdata[deas_pkg::CFG_KEEP_BIT];
        nxt_st.cfg_gie   = pwdata[deas_pkg::CFG_GIE_BIT];
        nxt_st.cfg_sleep = pwdata[deas_pkg::CFG_SLEEP_BIT];
      end
    end

    case (st_ff.state)
      deas_pkg::ST_IDLE: begin
        if (apb_wr && paddr == deas_pkg::CMD_OFF) begin
          if (pwdata[deas_pkg::CMD_RD_BIT] && pwdata[deas_pkg::CMD_WR_BIT]) begin
            irq_set[deas_pkg::IRQ_REFUSED] = 1'b1;
          end else if (pwdata[deas_pkg::CMD_RD_BIT] || pwdata[deas_pkg::CMD_WR_BIT]) begin
            nxt_st.state     = deas_pkg::ST_ISSUE;
            nxt_st.is_wr     = pwdata[deas_pkg::CMD_WR_BIT];
            nxt_st.verifying = 1'b0;
            nxt_st.step      = 4'h0;
          end
        end
      end
      deas_pkg::ST_ISSUE: begin
        if (op.cleanup && st_ff.cfg_keep) begin
          nxt_st.step = st_ff.step + 4'h1;
        end else begin
          port_go      = 1'b1;
          nxt_st.state = deas_pkg::ST_WAIT;
          if (op.irq_off) begin
            nxt_st.irq_hold = 1'b1;
          end
        end
      end
      deas_pkg::ST_WAIT: begin
        if (port_done) begin
          nxt_st.state = deas_pkg::ST_ISSUE;
          if (op.poll) begin
            nxt_st.last_poll = port_rdata;
            if (!port_rdata[op.poll_bit]) begin
              nxt_st.step = st_ff.step + 4'h1;
            end
          end else if (op.last) begin
            finish = 1'b1;
          end else begin
            nxt_st.step = st_ff.step + 4'h1;
          end
          if (op.irq_on) begin
            nxt_st.irq_hold = 1'b0;
          end
          if (op.capture) begin
            nxt_st.rd_byte = port_rdata;
          end
        end
      end
      default: begin
        nxt_st.state = deas_pkg::ST_IDLE;
      end
    endcase

    if (finish) begin
      if (st_ff.is_wr) begin
        irq_set[deas_pkg::IRQ_WR_DONE] = 1'b1;
        if (st_ff.cfg_vfy) begin
          nxt_st.is_wr     = 1'b0;
          nxt_st.verifying = 1'b1;
          nxt_st.step      = 4'h0;
        end else begin
          nxt_st.state = deas_pkg::ST_IDLE;
        end
      end else begin
        irq_set[deas_pkg::IRQ_RD_DONE] = 1'b1;
        nxt_st.state                   = deas_pkg::ST_IDLE;
        if (st_ff.verifying) begin
          nxt_st.vfy_ok = port_rdata == st_ff.cfg_data;
          irq_set[deas_pkg::IRQ_VFY_FAIL] = port_rdata != st_ff.cfg_data;
        end
      end
    end

    // Shadows of what the device was last told; only the checks read them.
    if (dev_wr) begin
      case (dev_addr)
        deas_pkg::DEV_PTR_LO:   nxt_st.sh_plo = dev_wdata;
        deas_pkg::DEV_PTR_HI:   nxt_st.sh_phi = dev_wdata;
        deas_pkg::DEV_ADDR_REG: nxt_st.addr_fresh = 1'b1;
        deas_pkg::DEV_IAP: begin
          nxt_st.sh_iap = dev_wdata;
          if (dev_wdata == deas_pkg::CTRL_RD_GO) begin
            nxt_st.addr_fresh = 1'b0;
          end
        end
        default: nxt_st.sh_iap = st_ff.sh_iap;
      endcase
    end

    // A pending sleep wish waits until the sequence has fully ended.
    nxt_st.sleep_out = nxt_st.cfg_sleep && (nxt_st.state == deas_pkg::ST_IDLE);
    nxt_st.gie_out   = nxt_st.cfg_gie && !nxt_st.irq_hold;

    if (psel && !penable) begin
      case (paddr)
        deas_pkg::CFG_OFF: begin
          nxt_st.prdata = '0;
          nxt_st.prdata[deas_pkg::CFG_ADDR_LSB +: 6] = st_ff.cfg_addr;
          nxt_st.prdata[deas_pkg::CFG_DATA_LSB +: 8] = st_ff.cfg_data;
          nxt_st.prdata[deas_pkg::CFG_VFY_BIT]       = st_ff.cfg_vfy;
          nxt_st.prdata[deas_pkg::CFG_KEEP_BIT]      = st_ff.cfg_keep;
          nxt_st.prdata[deas_pkg::CFG_GIE_BIT]       = st_ff.cfg_gie;
          nxt_st.prdata[deas_pkg::CFG_SLEEP_BIT]     = st_ff.cfg_sleep;
        end
        deas_pkg::STAT_OFF: begin
          nxt_st.prdata = '0;
          nxt_st.prdata[deas_pkg::STAT_BUSY_BIT]        = busy;
          nxt_st.prdata[deas_pkg::STAT_VFY_BIT]         = st_ff.vfy_ok;
          nxt_st.prdata[deas_pkg::STAT_BYTE_LSB +: 8]   = st_ff.rd_byte;
        end
        deas_pkg::IRQ_STAT_OFF: nxt_st.prdata = {28'h0000000, irq_status};
        deas_pkg::IRQ_MASK_OFF: nxt_st.prdata = {28'h0000000, irq_mask};
        default:                nxt_st.prdata = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  deas_sfr_port u_port (
    .clk       (clk),
    .arst_n    (arst_n),
    .go        (port_go),
    .go_we     (op.we),
    .go_addr   (op.addr),
    .go_wdata  (op.wdata),
    .done      (port_done),
    .rdata     (port_rdata),
    .dev_addr  (dev_addr),
    .dev_wdata (dev_wdata),
    .dev_wr    (dev_wr),
    .dev_rd    (dev_rd),
    .dev_rdata (dev_rdata)
  );

  deas_irq u_irq (
    .clk       (clk),
    .arst_n    (arst_n),
    .set       (irq_set),
    .clr_we    (apb_wr && paddr == deas_pkg::IRQ_STAT_OFF),
    .clr_data  (pwdata[deas_pkg::IRQ_W-1:0]),
    .mask_we   (apb_wr && paddr == deas_pkg::IRQ_MASK_OFF),
    .mask_data (pwdata[deas_pkg::IRQ_W-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  assign prdata            = st_ff.prdata;
  assign pready            = 1'b1;
  assign pslverr           = psel & penable & ~addr_mapped(paddr);
  assign global_irq_enable = st_ff.gie_out;
  assign sleep_req         = st_ff.sleep_out;

  sequence s_wr_permit;
    dev_wr && dev_addr == deas_pkg::DEV_IAP && dev_wdata == deas_pkg::CTRL_WR_PERMIT;
  endsequence

  sequence s_wr_launch;
    dev_wr && dev_addr == deas_pkg::DEV_IAP && dev_wdata == deas_pkg::CTRL_WR_GO;
  endsequence

  a_launch_follows: assert property (@(posedge clk) disable iff (!arst_n)
    s_wr_permit |=> !(dev_wr || dev_rd) [*2] ##1 s_wr_launch)
    else $error("write launch did not follow write permit directly");

  a_gie_off_launch: assert property (@(posedge clk) disable iff (!arst_n)
    s_wr_launch |-> !global_irq_enable)
    else $error("interrupts enabled at write launch");

  a_gie_restored: assert property (@(posedge clk) disable iff (!arst_n)
    s_wr_launch |-> ##2 (global_irq_enable == st_ff.cfg_gie))
    else $error("interrupt enable not restored after launch");

  a_sleep_blocked: assert property (@(posedge clk) disable iff (!arst_n)
    busy |-> !sleep_req)
    else $error("sleep requested during a cycle");

  a_addr_reload: assert property (@(posedge clk) disable iff (!arst_n)
    (dev_wr && dev_addr == deas_pkg::DEV_IAP && dev_wdata == deas_pkg::CTRL_RD_GO)
      |-> st_ff.addr_fresh)
    else $error("read launched without reloading the address");

  a_permit_idle: assert property (@(posedge clk) disable iff (!arst_n)
    !busy |-> !st_ff.sh_iap[deas_pkg::WR_PERMIT_BIT])
    else $error("write permit left set while idle");

  a_ctrl_pointer: assert property (@(posedge clk) disable iff (!arst_n)
    ((dev_wr || dev_rd) && dev_addr == deas_pkg::DEV_IAP)
      |-> st_ff.sh_plo == deas_pkg::CTRL_PTR_LO && st_ff.sh_phi == deas_pkg::CTRL_PTR_HI)
    else $error("control register accessed with wrong pointer");

  a_data_after_poll: assert property (@(posedge clk) disable iff (!arst_n)
    (dev_rd && dev_addr == deas_pkg::DEV_DATA_REG)
      |-> !st_ff.last_poll[deas_pkg::RD_LAUNCH_BIT])
    else $error("data read before read launch cleared");

  a_wr_polled: assert property (@(posedge clk) disable iff (!arst_n)
    irq_set[deas_pkg::IRQ_WR_DONE] |-> !st_ff.last_poll[deas_pkg::WR_LAUNCH_BIT])
    else $error("write reported done before launch cleared");

  a_cleanup_end: assert property (@(posedge clk) disable iff (!arst_n)
    ($fell(busy) && !st_ff.cfg_keep) |-> st_ff.sh_phi == deas_pkg::SECTOR0_HI
      && st_ff.sh_iap == deas_pkg::CTRL_CLEAR)
    else $error("sequence ended without closing the control register");

endmodule : deas_host

// ### testbench/deas_dev_model.sv
module deas_dev_model #(
  parameter int WR_CYCLES = 20
) (
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] dev_addr,
  input  wire logic [7:0] dev_wdata,
  input  wire logic       dev_wr,
  input  wire logic       dev_rd,
  output logic [7:0]      dev_rdata,
  input  wire logic       global_irq_enable,
  input  wire logic       sleep_req,
  output logic [7:0]      viol
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] mem [64];
  logic [5:0] addr_ff;
  logic [7:0] data_ff, plo_ff, phi_ff, v;
  logic [3:0] ctrl_ff;
  logic       write_done_flag, permit_ff, sel;
  int         cnt_ff;
  assign sel = phi_ff == deas_pkg::CTRL_PTR_HI && plo_ff == deas_pkg::CTRL_PTR_LO;
  always_comb begin
    case (dev_addr)
      deas_pkg::DEV_ADDR_REG: v = {2'b00, addr_ff};
      deas_pkg::DEV_DATA_REG: v = data_ff;
      deas_pkg::DEV_PTR_LO:   v = plo_ff;
      deas_pkg::DEV_PTR_HI:   v = phi_ff;
      deas_pkg::DEV_IAP:      v = sel ? {4'h0, ctrl_ff} : 8'h00;
      default:                v = 8'h00;
    endcase
    // Outside a read the port shows the inverse, so a late sample cannot pass by luck.
    dev_rdata = dev_rd ? v : ~v;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      for (int i = 0; i < 64; i++) mem[i] <= {2'b10, i[5:0]};
      {addr_ff, data_ff, plo_ff, phi_ff, ctrl_ff} <= '0;
      {write_done_flag, permit_ff, viol} <= '0;
      cnt_ff <= 0;
    end else begin
      if (dev_wr || dev_rd)
        permit_ff <= dev_wr && sel && dev_addr == deas_pkg::DEV_IAP && dev_wdata[3:2] == 2'b10;
      if (cnt_ff > 0 && sleep_req) begin
        viol <= viol + 8'h01;
        cnt_ff <= 0;
        ctrl_ff[2] <= 1'b0;
        ctrl_ff[0] <= 1'b0;
      end else if (cnt_ff > 0) begin
        cnt_ff <= cnt_ff - 1;
        if (cnt_ff == 1 && ctrl_ff[2]) begin
          mem[addr_ff] <= data_ff;
          ctrl_ff[2] <= 1'b0;
          write_done_flag <= 1'b1;
        end else if (cnt_ff == 1) begin
          data_ff <= mem[addr_ff];
          ctrl_ff[0] <= 1'b0;
        end
      end
      if (dev_wr) begin
        case (dev_addr)
          deas_pkg::DEV_ADDR_REG: addr_ff <= dev_wdata[5:0];
          deas_pkg::DEV_DATA_REG: data_ff <= dev_wdata;
          deas_pkg::DEV_PTR_LO:   plo_ff <= dev_wdata;
          deas_pkg::DEV_PTR_HI:   phi_ff <= dev_wdata;
          deas_pkg::DEV_IAP: if (sel) begin
            ctrl_ff[3] <= dev_wdata[3];
            ctrl_ff[1] <= dev_wdata[1];
            if (dev_wdata[2] && ctrl_ff[3] && cnt_ff == 0) begin
              ctrl_ff[2] <= 1'b1;
              cnt_ff <= WR_CYCLES;
              if (!permit_ff || global_irq_enable) viol <= viol + 8'h01;
            end
            if (dev_wdata[0] && ctrl_ff[1] && cnt_ff == 0) begin
              ctrl_ff[0] <= 1'b1;
              cnt_ff <= 2;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule : deas_dev_model

// ### testbench/deas_host_tb.sv
module deas_host_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, e;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, q, prdata;
  logic        pready, pslverr, irq, dev_wr, dev_rd, gie, sleep_req;
  logic [7:0]  dev_addr, dev_wdata, dev_rdata, viol;
  int          fails = 0, samples_checked = 0;
  always #10 clk = ~clk;
  deas_host DUT (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .dev_addr(dev_addr), .dev_wdata(dev_wdata), .dev_wr(dev_wr), .dev_rd(dev_rd),
    .dev_rdata(dev_rdata), .global_irq_enable(gie), .sleep_req(sleep_req));
  deas_dev_model M (.clk(clk), .arst_n(arst_n), .dev_addr(dev_addr), .dev_wdata(dev_wdata),
    .dev_wr(dev_wr), .dev_rd(dev_rd), .dev_rdata(dev_rdata), .global_irq_enable(gie),
    .sleep_req(sleep_req), .viol(viol));
  task wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : wrap_up
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  // Only the watchdog ends a hung poll, so a stuck sequence still fails.
  task poll_idle;
    do begin
      apb(1'b0, deas_pkg::STAT_OFF, '0);
    end while (q[deas_pkg::STAT_BUSY_BIT] !== 1'b0);
  endtask : poll_idle
  task t_write_verify;
    apb(1'b0, deas_pkg::IRQ_MASK_OFF, '0);
    chk("mask reset", q, 32'h0000_0000);
    apb(1'b1, deas_pkg::IRQ_MASK_OFF, 32'h0000_0002);
    apb(1'b1, deas_pkg::CFG_OFF, 32'h0005_a53f);
    apb(1'b1, deas_pkg::CMD_OFF, 32'h0000_0002);
    poll_idle();
    chk("cell 3f", {24'h0, M.mem[63]}, 32'h0000_00a5);
    chk("verify stat", q & 32'h0000_ff02, 32'h0000_a502);
    apb(1'b0, deas_pkg::IRQ_STAT_OFF, '0);
    chk("irq status", q, 32'h0000_0003);
    chk("irq line", {31'h0, irq}, 32'h1);
    chk("done flag", {31'h0, M.write_done_flag}, 32'h1);
    chk("host faults", {24'h0, viol}, 32'h0);
    chk("ctrl closed", {20'h0, M.ctrl_ff, M.phi_ff}, 32'h0);
    apb(1'b1, deas_pkg::IRQ_STAT_OFF, 32'h0000_000f);
    apb(1'b0, deas_pkg::IRQ_STAT_OFF, '0);
    chk("irq cleared", {q[30:0], irq}, 32'h0);
    $display("test write_verify done");
  endtask : t_write_verify
  task t_read_pair;
    apb(1'b1, deas_pkg::CFG_OFF, 32'h0000_003e);
    apb(1'b1, deas_pkg::CMD_OFF, 32'h0000_0001);
    poll_idle();
    chk("byte 3e", q & 32'h0000_ff00, 32'h0000_be00);
    apb(1'b1, deas_pkg::CFG_OFF, 32'h0000_003f);
    apb(1'b1, deas_pkg::CMD_OFF, 32'h0000_0001);
    poll_idle();
    chk("byte 3f", q & 32'h0000_ff00, 32'h0000_a500);
    apb(1'b0, deas_pkg::IRQ_STAT_OFF, '0);
    chk("masked read done", {q[30:0], irq}, 32'h0000_0002);
    apb(1'b1, deas_pkg::IRQ_STAT_OFF, 32'h0000_000f);
    $display("test read_pair done");
  endtask : t_read_pair
  task t_refuse;
    apb(1'b1, deas_pkg::CMD_OFF, 32'h0000_0003);
    apb(1'b0, deas_pkg::IRQ_STAT_OFF, '0);
    chk("refused flag", q, 32'h0000_0008);
    apb(1'b0, 12'h100, '0);
    chk("unmapped", {q[30:0], e}, 32'h0000_0001);
    apb(1'b1, deas_pkg::IRQ_STAT_OFF, 32'h0000_000f);
    // A CFG write in mid-sequence must be refused; keep stays set, so no cleanup.
    apb(1'b1, deas_pkg::CFG_OFF, 32'h0002_003e);
    apb(1'b1, deas_pkg::CMD_OFF, 32'h0000_0001);
    apb(1'b1, deas_pkg::CFG_OFF, 32'h0000_0000);
    poll_idle();
    chk("keep byte", q & 32'h0000_ff00, 32'h0000_be00);
    chk("kept open", {20'h0, M.ctrl_ff, M.phi_ff}, 32'h0000_0201);
    apb(1'b0, deas_pkg::IRQ_STAT_OFF, '0);
    chk("busy cfg refused", q, 32'h0000_0009);
    apb(1'b1, deas_pkg::IRQ_STAT_OFF, 32'h0000_000f);
    $display("test refuse done");
  endtask : t_refuse
  task t_sleep;
    apb(1'b1, deas_pkg::CFG_OFF, 32'h0008_003e);
    chk("sleep idle", {31'h0, sleep_req}, 32'h1);
    apb(1'b1, deas_pkg::CMD_OFF, 32'h0000_0001);
    poll_idle();
    chk("byte in sleep", q & 32'h0000_ff00, 32'h0000_be00);
    chk("sleep faults", {16'h0, viol, 7'h0, sleep_req}, 32'h1);
    $display("test sleep done");
  endtask : t_sleep
  initial begin
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    t_write_verify();
    t_read_pair();
    t_refuse();
    t_sleep();
    wrap_up();
  end
  initial begin
    #400000;
    fails++;
    wrap_up();
  end
endmodule : deas_host_tb
